/* src/opd_top.sv */
`timescale 1ns/1ps
`include "opd_regs.svh"

module opd_top
#(
    parameter int unsigned TICK_CYCLES =
        `OPD_TIME_STEP_NS / `OPD_CLK_PERIOD_NS
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire opd_pkg::opd_addr_t reg_addr,
    input wire opd_pkg::opd_word_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output opd_pkg::opd_word_t reg_rdata,
    input wire logic [2:0] phase_current_present,
    input wire logic [15:0] motor_speed_mag,
    input wire logic [15:0] command_speed_mag,
    input wire logic servo_on,
    input wire logic other_alarm_active,
    input wire logic brake_interlock_output,
    output logic open_phase_alarm,
    output logic [3:0] open_phase_sub_code,
    output logic irq
);
    import opd_pkg::*;

    localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);
    localparam logic [15:0] AUTO_STEPS =
        16'(`OPD_AUTO_TIME_MS / `OPD_TIME_STEP_MS);

    opd_state_t s_reg;
    opd_state_t s_next;

    logic single_open;
    logic multi_open;
    logic mode_on;
    logic gate;
    logic [15:0] sel_speed;
    logic [15:0] thr_speed;
    logic [15:0] time_lim;
    logic raise;
    logic armed;
    logic clr_alarm;
    logic [1:0] irq_clr;
    logic [1:0] irq_ev;

    // ==========================================================
    // Detection start speed from detection time
    function automatic logic [15:0] start_speed(input logic [15:0] t);
        logic [15:0] diff;
        diff = AUTO_STEPS - t;
        if (t == 16'h0000 || t >= AUTO_STEPS)
        begin
            return `OPD_FIXED_SPEED;
        end
        return `OPD_FIXED_SPEED + 16'(diff * `OPD_START_SPD_SLOPE);
    endfunction : start_speed

    // ==========================================================
    // Phase monitor
    opd_phase_mon u_mon
    (
        .clk(clk),
        .reset_n(reset_n),
        .phase_current_present(phase_current_present),
        .single_open(single_open),
        .multi_open(multi_open)
    );

    // ==========================================================
    // Gating
    always_comb
    begin
        mode_on = (s_reg.en_sel == `OPD_EN_AUTO)
            || (s_reg.en_sel == `OPD_EN_TIMED);
        sel_speed = (s_reg.judge_sel == `OPD_JUDGE_CMD)
            ? command_speed_mag : motor_speed_mag;
        if (s_reg.en_sel == `OPD_EN_TIMED)
        begin
            thr_speed = start_speed(s_reg.detect_time);
        end
        else
        begin
            thr_speed = `OPD_FIXED_SPEED;
        end
        if (s_reg.en_sel == `OPD_EN_TIMED
            && s_reg.detect_time != 16'h0000)
        begin
            time_lim = s_reg.detect_time;
        end
        else
        begin
            time_lim = AUTO_STEPS;
        end
        gate = mode_on
            && (s_reg.motorless_sel != `OPD_MOTORLESS_ON)
            && !other_alarm_active
            && !brake_interlock_output
            && servo_on
            && (sel_speed >= thr_speed);
    end

    // ==========================================================
    // Next state
    always_comb
    begin
        s_next = s_reg;
        raise = 1'b0;
        armed = gate && !s_reg.gate_d;
        clr_alarm = 1'b0;
        irq_clr = 2'h0;
        s_next.gate_d = gate;
        s_next.rdata = '0;

        // Register writes
        if (reg_wr)
        begin
            unique case (reg_addr)
                `OPD_CTRL_OFS:
                begin
                    s_next.en_sel = reg_wdata[`OPD_CTRL_EN_LSB +: 2];
                    s_next.judge_sel = reg_wdata[`OPD_CTRL_JUDGE_BIT];
                    s_next.motorless_sel =
                        reg_wdata[`OPD_CTRL_MOTORLESS_BIT];
                    clr_alarm = reg_wdata[`OPD_CTRL_CLR_BIT];
                end
                `OPD_DTIME_OFS:
                begin
                    s_next.detect_time = reg_wdata[15:0];
                end
                `OPD_IRQ_STAT_OFS:
                begin
                    irq_clr = reg_wdata[1:0];
                end
                `OPD_IRQ_MASK_OFS:
                begin
                    s_next.irq_mask = reg_wdata[1:0];
                end
                default:
                begin
                end
            endcase
        end

        if (clr_alarm)
        begin
            s_next.alarm = 1'b0;
            s_next.sub_code = 4'h0;
        end

        // Open-phase timer
        if (gate && single_open && !s_reg.alarm)
        begin
            if (s_reg.tick_cnt >= TICK_LAST)
            begin
                s_next.tick_cnt = '0;
                if (17'(s_reg.step_cnt) + 17'h00001 >= 17'(time_lim))
                begin
                    raise = 1'b1;
                    s_next.step_cnt = '0;
                end
                else
                begin
                    s_next.step_cnt = s_reg.step_cnt + 16'h0001;
                end
            end
            else
            begin
                s_next.tick_cnt = s_reg.tick_cnt + 32'h00000001;
            end
        end
        else
        begin
            s_next.tick_cnt = '0;
            s_next.step_cnt = '0;
        end

        // Alarm latch, set wins over clear
        if (raise)
        begin
            s_next.alarm = 1'b1;
            if (s_reg.judge_sel == `OPD_JUDGE_CMD)
            begin
                s_next.sub_code = `OPD_SUB_CMD;
            end
            else
            begin
                s_next.sub_code = `OPD_SUB_MOTOR;
            end
        end

        // Interrupt status
        irq_ev = 2'h0;
        irq_ev[`OPD_IRQ_ALARM_BIT] = raise;
        irq_ev[`OPD_IRQ_ARMED_BIT] = armed;
        s_next.irq_stat = (s_reg.irq_stat & ~irq_clr) | irq_ev;
        s_next.irq = |(s_next.irq_stat & s_next.irq_mask);

        // Register reads
        if (reg_rd)
        begin
            unique case (reg_addr)
                `OPD_CTRL_OFS:
                begin
                    s_next.rdata[`OPD_CTRL_EN_LSB +: 2] = s_reg.en_sel;
                    s_next.rdata[`OPD_CTRL_JUDGE_BIT] = s_reg.judge_sel;
                    s_next.rdata[`OPD_CTRL_MOTORLESS_BIT] =
                        s_reg.motorless_sel;
                end
                `OPD_DTIME_OFS:
                begin
                    s_next.rdata[15:0] = s_reg.detect_time;
                end
                `OPD_STATUS_OFS:
                begin
                    s_next.rdata[0] = s_reg.alarm;
                    s_next.rdata[`OPD_STAT_SUB_LSB +: 4] = s_reg.sub_code;
                    s_next.rdata[`OPD_STAT_CODE_LSB +: 8] =
                        `OPD_ALARM_CODE;
                    s_next.rdata[`OPD_STAT_GATE_BIT] = s_reg.gate_d;
                    s_next.rdata[`OPD_STAT_OPEN_BIT] =
                        single_open || multi_open;
                end
                `OPD_IRQ_STAT_OFS:
                begin
                    s_next.rdata[1:0] = s_reg.irq_stat;
                end
                `OPD_IRQ_MASK_OFS:
                begin
                    s_next.rdata[1:0] = s_reg.irq_mask;
                end
                `OPD_START_SPD_OFS:
                begin
                    s_next.rdata[15:0] = thr_speed;
                end
                default:
                begin
                    s_next.rdata = '0;
                end
            endcase
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_reg <= '0;
            s_reg.en_sel <= `OPD_EN_OFF;
            s_reg.detect_time <= `OPD_DTIME_RST;
            s_reg.irq_mask <= `OPD_MASK_RST;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign reg_rdata = s_reg.rdata;
    assign open_phase_alarm = s_reg.alarm;
    assign open_phase_sub_code = s_reg.sub_code;
    assign irq = s_reg.irq;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    chk_alarm_cause: assert property (
        $rose(open_phase_alarm) |-> $past(single_open) && $past(gate))
        else $error("alarm raised without a gated open phase");

    chk_mode_enabled: assert property (
        $rose(open_phase_alarm) |-> $past(mode_on))
        else $error("alarm raised while detection disabled");

    chk_other_alarm: assert property (
        other_alarm_active |=> s_reg.tick_cnt == 32'h00000000)
        else $error("counting while another alarm is active");

    chk_motorless_off: assert property (
        s_reg.motorless_sel == `OPD_MOTORLESS_ON
        |=> s_reg.tick_cnt == 32'h00000000 && !$rose(open_phase_alarm))
        else $error("detection active in motor-less operation");

    chk_fixed_speed: assert property (
        s_reg.en_sel == `OPD_EN_AUTO && (!servo_on
        || sel_speed < `OPD_FIXED_SPEED)
        |=> s_reg.tick_cnt == 32'h00000000)
        else $error("counting below fixed speed or servo off");

    chk_cmd_speed: assert property (
        s_reg.en_sel == `OPD_EN_AUTO && s_reg.judge_sel == `OPD_JUDGE_CMD
        && command_speed_mag < `OPD_FIXED_SPEED
        |=> s_reg.tick_cnt == 32'h00000000)
        else $error("counting below command speed threshold");

    chk_brake_block: assert property (
        brake_interlock_output |=> s_reg.tick_cnt == 32'h00000000
        && s_reg.step_cnt == 16'h0000)
        else $error("counting while brake interlock is on");

    chk_timed_start: assert property (
        s_reg.en_sel == `OPD_EN_TIMED
        && sel_speed < start_speed(s_reg.detect_time)
        |=> s_reg.tick_cnt == 32'h00000000)
        else $error("counting below detection start speed");

    chk_time_limit: assert property (
        $rose(open_phase_alarm) |-> 17'($past(s_reg.step_cnt))
        + 17'h00001 >= 17'($past(time_lim)))
        else $error("alarm before detection time elapsed");

    chk_time_ignored: assert property (
        s_reg.en_sel != `OPD_EN_TIMED |-> time_lim == AUTO_STEPS)
        else $error("detection time used outside timed mode");

    chk_lapse_clear: assert property (
        !gate || !single_open |=> s_reg.step_cnt == 16'h0000)
        else $error("step count kept after gating lapsed");

    chk_cmd_sub: assert property (
        $rose(open_phase_alarm) && $past(s_reg.judge_sel) == `OPD_JUDGE_CMD
        |-> open_phase_sub_code != `OPD_SUB_MOTOR)
        else $error("sub-alarm 2 raised under command speed judgment");

    chk_irq_level: assert property (
        s_reg.alarm && s_reg.irq_mask[`OPD_IRQ_ALARM_BIT]
        && $rose(s_reg.alarm) |-> irq)
        else $error("unmasked alarm event did not raise interrupt");

    cov_auto_alarm: cover property (
        s_reg.en_sel == `OPD_EN_AUTO && $rose(open_phase_alarm));
    cov_timed_alarm: cover property (
        s_reg.en_sel == `OPD_EN_TIMED && $rose(open_phase_alarm));
    cov_irq: cover property ($rose(irq));
    cov_clear: cover property ($fell(open_phase_alarm));

endmodule : opd_top

/* src/opd_regs.svh */
`ifndef OPD_REGS_SVH
`define OPD_REGS_SVH

// ==========================================================
// Register offsets
`define OPD_ADDR_W 8
`define OPD_CTRL_OFS 8'h00
`define OPD_DTIME_OFS 8'h04
`define OPD_STATUS_OFS 8'h08
`define OPD_IRQ_STAT_OFS 8'h0C
`define OPD_IRQ_MASK_OFS 8'h10
`define OPD_START_SPD_OFS 8'h14

// ==========================================================
// Field positions
`define OPD_CTRL_EN_LSB 0
`define OPD_CTRL_JUDGE_BIT 2
`define OPD_CTRL_MOTORLESS_BIT 3
`define OPD_CTRL_CLR_BIT 8
`define OPD_STAT_SUB_LSB 4
`define OPD_STAT_CODE_LSB 8
`define OPD_STAT_GATE_BIT 16
`define OPD_STAT_OPEN_BIT 17
`define OPD_IRQ_ALARM_BIT 0
`define OPD_IRQ_ARMED_BIT 1

// ==========================================================
// Encodings and reset values
`define OPD_EN_OFF 2'h0
`define OPD_EN_AUTO 2'h1
`define OPD_EN_TIMED 2'h2
`define OPD_JUDGE_MOTOR 1'h0
`define OPD_JUDGE_CMD 1'h1
`define OPD_MOTORLESS_ON 1'h1
`define OPD_ALARM_CODE 8'h8B
`define OPD_SUB_CMD 4'h1
`define OPD_SUB_MOTOR 4'h2
`define OPD_CTRL_RST 4'h0
`define OPD_DTIME_RST 16'h0000
`define OPD_MASK_RST 2'h0

// ==========================================================
// Timing and speed
`define OPD_CLK_PERIOD_NS 4
`define OPD_TIME_STEP_NS 100000000
`define OPD_AUTO_TIME_MS 3000
`define OPD_TIME_STEP_MS 100
`define OPD_FIXED_SPEED 16'h0032
`define OPD_START_SPD_SLOPE 16'h000A

`endif

/* src/opd_pkg.sv */
package opd_pkg;

    typedef logic [31:0] opd_word_t;
    typedef logic [7:0] opd_addr_t;

    typedef struct packed {
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic single_open;
        logic multi_open;
    } opd_mon_state_t;

    typedef struct packed {
        logic [1:0] en_sel;
        logic judge_sel;
        logic motorless_sel;
        logic [15:0] detect_time;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic [31:0] tick_cnt;
        logic [15:0] step_cnt;
        logic alarm;
        logic [3:0] sub_code;
        logic gate_d;
        logic irq;
        logic [31:0] rdata;
    } opd_state_t;

endpackage : opd_pkg

/* src/opd_phase_mon.sv */
`timescale 1ns/1ps
`include "opd_regs.svh"

module opd_phase_mon
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [2:0] phase_current_present,
    output logic single_open,
    output logic multi_open
);
    import opd_pkg::*;

    opd_mon_state_t s_reg;
    opd_mon_state_t s_next;

    // ==========================================================
    // Phase synchroniser and open-phase decode
    always_comb
    begin
        s_next = s_reg;
        s_next.sync1 = phase_current_present;
        s_next.sync2 = s_reg.sync1;
        s_next.single_open = ($countones(~s_reg.sync2) == 1);
        s_next.multi_open = ($countones(~s_reg.sync2) > 1);
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_reg <= '0;
            s_reg.sync1 <= 3'h7;
            s_reg.sync2 <= 3'h7;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign single_open = s_reg.single_open;
    assign multi_open = s_reg.multi_open;

    // ==========================================================
    // Checks
    chk_single_only: assert property (@(posedge clk) disable iff (!reset_n)
        single_open |-> $countones(~$past(s_reg.sync2)) == 1)
        else $error("single open flag without exactly one open phase");

endmodule : opd_phase_mon

/* bench/opd_wiring_model.sv */
`timescale 1ns/1ps

// ==========================================================
// Motor power wiring: a cut phase carries no current
module opd_wiring_model
(
    input wire logic [2:0] open_cut,
    output logic [2:0] phase_current_present
);
    assign phase_current_present = ~open_cut;
endmodule : opd_wiring_model

/* bench/motor_output_open_phase_detector_test.sv */
`timescale 1ns/1ps
`include "opd_regs.svh"

`define OPD_CHECK(what, exp, got) \
    begin \
        n_tests++; \
        if ((got) !== (exp)) \
        begin \
            num_errors++; \
            $display("mismatch %s expected %0h seen %0h", what, exp, got); \
        end \
    end

// ==========================================================
// Bench
module motor_output_open_phase_detector_test;
    import opd_pkg::*;
    localparam int unsigned TICK = 2;
    localparam int LIM = 30 * TICK;
    localparam int CEIL = 20000;
    logic clk = 1'h0;
    logic reset_n = 1'h0;
    opd_addr_t reg_addr = 8'h00;
    opd_word_t reg_wdata = 32'h0;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    opd_word_t reg_rdata;
    logic [2:0] cut = 3'h0;
    logic [2:0] phase_present;
    logic [15:0] motor_speed_mag = 16'h0000;
    logic [15:0] command_speed_mag = 16'h0000;
    logic servo_on = 1'h0;
    logic other_alarm_active = 1'h0;
    logic brake_interlock_output = 1'h0;
    logic open_phase_alarm;
    logic [3:0] open_phase_sub_code;
    logic irq;
    int num_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    opd_word_t rd;
    int n;

    opd_wiring_model wiring_u
    (
        .open_cut(cut),
        .phase_current_present(phase_present)
    );

    opd_top #(.TICK_CYCLES(TICK)) dut_u
    (
        .clk(clk),
        .reset_n(reset_n),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .phase_current_present(phase_present),
        .motor_speed_mag(motor_speed_mag),
        .command_speed_mag(command_speed_mag),
        .servo_on(servo_on),
        .other_alarm_active(other_alarm_active),
        .brake_interlock_output(brake_interlock_output),
        .open_phase_alarm(open_phase_alarm),
        .open_phase_sub_code(open_phase_sub_code),
        .irq(irq)
    );

    always #2 clk = ~clk;

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == CEIL)
        begin
            num_errors++;
            conclude();
        end
    end

    // ==========================================================
    // Bus and helpers
    function automatic opd_word_t mk_ctrl(logic [1:0] en, logic j, logic m);
        return {23'h0, 1'h1, 4'h0, m, j, en};
    endfunction : mk_ctrl

    task automatic reg_write(input opd_addr_t a, input opd_word_t d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge clk);
        reg_wr <= 1'h0;
        @(posedge clk);
    endtask : reg_write

    // Read data stand in the cycle after the strobe, taken at its end
    task automatic reg_read(input opd_addr_t a, output opd_word_t d);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clk);
        reg_rd <= 1'h0;
        @(posedge clk);
        d = reg_rdata;
    endtask : reg_read

    // Cut the phases set in c and count edges until the alarm or the limit
    task automatic watch(input logic [2:0] c, input int hi, output int k);
        cut <= c;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (open_phase_alarm !== 1'h1 && k < hi);
    endtask : watch

    task automatic setup(input opd_word_t ctrl, input opd_word_t dt);
        cut <= 3'h0;
        other_alarm_active <= 1'h0;
        brake_interlock_output <= 1'h0;
        servo_on <= 1'h1;
        reg_write(`OPD_DTIME_OFS, dt);
        reg_write(`OPD_CTRL_OFS, ctrl);
        reg_write(`OPD_IRQ_STAT_OFS, 32'h3);
        repeat (4) @(posedge clk);
    endtask : setup

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        reg_read(`OPD_CTRL_OFS, rd);
        `OPD_CHECK("ctrl reset", 32'h0, rd)
        reg_read(`OPD_DTIME_OFS, rd);
        `OPD_CHECK("dtime reset", 32'h0, rd)
        reg_read(`OPD_IRQ_MASK_OFS, rd);
        `OPD_CHECK("mask reset", 32'h0, rd)
        reg_read(`OPD_STATUS_OFS, rd);
        `OPD_CHECK("status reset", 16'h8B00, rd[15:0])
        reg_read(8'h18, rd);
        `OPD_CHECK("unmapped read", 32'h0, rd)
        servo_on <= 1'h1;
        motor_speed_mag <= 16'h0064;
        watch(3'h2, LIM + 6, n);
        `OPD_CHECK("alarm while off", 1'h0, open_phase_alarm)
        reg_write(`OPD_CTRL_OFS, mk_ctrl(2'h3, 1'h0, 1'h0));
        watch(3'h2, LIM + 6, n);
        `OPD_CHECK("alarm at select 3", 1'h0, open_phase_alarm)
        $display("test reset done");
    endtask : t_reset

    task automatic t_auto_motor();
        setup(mk_ctrl(`OPD_EN_AUTO, `OPD_JUDGE_MOTOR, 1'h0), 32'h5);
        reg_write(`OPD_IRQ_MASK_OFS, 32'h1);
        motor_speed_mag <= 16'h0031;
        watch(3'h2, LIM + 6, n);
        `OPD_CHECK("alarm below 50", 1'h0, open_phase_alarm)
        motor_speed_mag <= 16'h0032;
        watch(3'h2, LIM + 6, n);
        `OPD_CHECK("auto latency", 1'h1, n >= LIM && n <= LIM + 5)
        `OPD_CHECK("motor sub", 4'h2, open_phase_sub_code)
        `OPD_CHECK("irq raised", 1'h1, irq)
        reg_read(`OPD_STATUS_OFS, rd);
        `OPD_CHECK("status alarm", 18'h38B21, rd[17:0])
        reg_read(`OPD_IRQ_STAT_OFS, rd);
        `OPD_CHECK("irq status", 32'h3, rd)
        reg_write(`OPD_IRQ_STAT_OFS, 32'h1);
        `OPD_CHECK("irq cleared", 1'h0, irq)
        reg_write(`OPD_CTRL_OFS, mk_ctrl(`OPD_EN_AUTO, 1'h0, 1'h0));
        `OPD_CHECK("alarm cleared", 1'h0, open_phase_alarm)
        $display("test auto motor done");
    endtask : t_auto_motor

    task automatic t_cmd();
        setup(mk_ctrl(`OPD_EN_AUTO, `OPD_JUDGE_CMD, 1'h0), 32'h0);
        motor_speed_mag <= 16'h0000;
        command_speed_mag <= 16'h0031;
        watch(3'h4, LIM + 6, n);
        `OPD_CHECK("cmd below 50", 1'h0, open_phase_alarm)
        command_speed_mag <= 16'h0032;
        watch(3'h4, LIM + 6, n);
        `OPD_CHECK("cmd alarm", 1'h1, open_phase_alarm)
        `OPD_CHECK("cmd sub", 4'h1, open_phase_sub_code)
        $display("test command done");
    endtask : t_cmd

    task automatic t_inhibit();
        for (int k = 0; k < 4; k++)
        begin
            setup(mk_ctrl(`OPD_EN_AUTO, 1'h0, k == 1), 32'h0);
            motor_speed_mag <= 16'h0064;
            other_alarm_active <= (k == 0);
            brake_interlock_output <= (k == 2);
            servo_on <= (k != 3);
            watch(3'h1, LIM + 6, n);
            `OPD_CHECK("inhibit", 1'h0, open_phase_alarm)
        end
        $display("test inhibit done");
    endtask : t_inhibit

    task automatic t_timed();
        setup(mk_ctrl(`OPD_EN_TIMED, 1'h0, 1'h0), 32'h5);
        reg_read(`OPD_START_SPD_OFS, rd);
        `OPD_CHECK("start speed", 32'h12C, rd)
        motor_speed_mag <= 16'h012B;
        watch(3'h2, LIM + 6, n);
        `OPD_CHECK("below start", 1'h0, open_phase_alarm)
        motor_speed_mag <= 16'h012C;
        watch(3'h2, LIM + 6, n);
        `OPD_CHECK("timed latency", 1'h1, n >= 10 && n <= 15)
        setup(mk_ctrl(`OPD_EN_AUTO, 1'h0, 1'h0), 32'h5);
        watch(3'h2, LIM + 6, n);
        `OPD_CHECK("time ignored", 1'h1, n >= LIM && n <= LIM + 5)
        setup(mk_ctrl(`OPD_EN_TIMED, 1'h0, 1'h0), 32'h0);
        motor_speed_mag <= 16'h0032;
        watch(3'h2, LIM + 6, n);
        `OPD_CHECK("zero is auto", 1'h1, n >= LIM && n <= LIM + 5)
        $display("test timed done");
    endtask : t_timed

    task automatic t_multi_lapse();
        setup(mk_ctrl(`OPD_EN_AUTO, 1'h0, 1'h0), 32'h0);
        watch(3'h3, LIM + 6, n);
        `OPD_CHECK("two open", 1'h0, open_phase_alarm)
        watch(3'h2, 40, n);
        servo_on <= 1'h0;
        repeat (2) @(posedge clk);
        servo_on <= 1'h1;
        watch(3'h2, LIM + 6, n);
        `OPD_CHECK("restart count", 1'h1, n >= LIM && n <= LIM + 5)
        $display("test lapse done");
    endtask : t_multi_lapse

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : conclude

    initial
    begin
        repeat (10) @(posedge clk);
        reset_n <= 1'h1;
        @(posedge clk);
        t_reset();
        t_auto_motor();
        t_cmd();
        t_inhibit();
        t_timed();
        t_multi_lapse();
        conclude();
    end
endmodule : motor_output_open_phase_detector_test
